// ===== rtl/card_bus_host_port.sv
// Purpose: Host controller driving a 16-bit card bus into a module
// Assumes: Card outputs are synchronous to CORE_CLK_I
// Notes:   One access at a time; wait stretches the cycle, busy delays the next one
`timescale 1ns/1ps
// Summary of operation
// - Host holds the strobe of the current access active while cycle extend stays low.
// - Host drives card reset high to reinitialise the card.
// - Attribute select low steers memory accesses to attribute space.
// - Memory writes use the memory write strobe.
// - I/O writes use the I/O write strobe with data driven.
// - I/O reads use the I/O read strobe; card drives the data.
// - Odd byte enable is asserted as select for every access.
module card_bus_host_port
(
   // Clock and reset
   input  wire logic                CORE_CLK_I,
   input  wire logic                ARST_N_I,
   // User request port
   input  wire logic                REQ_VALID_I,
   output logic                     REQ_READY_O,
   input  wire logic                REQ_WRITE_I,
   input  wire logic [1:0]          REQ_KIND_I,
   input  wire logic [9:0]          REQ_ADDR_I,
   input  wire logic [15:0]         REQ_WDATA_I,
   input  wire logic                IO_MODE_I,
   input  wire logic                CARD_RESET_REQ_I,
   // User answer port
   output logic                     RSP_VALID_O,
   output logic [15:0]              RSP_RDATA_O,
   output logic                     RSP_NO_ACK_O,
   output logic                     IRQ_O,
   output logic                     CARD_BUSY_O,
   output logic                     STATUS_EVENT_O,
   output logic                     WIDE_IO_O,
   // Card pins
   output logic                     HOST_RESET_O,
   output logic [9:0]               ADDR_O,
   output logic                     ATTR_MEM_SELECT_N_O,
   output logic                     ODD_BYTE_ENABLE_N_O,
   output logic                     MEM_WRITE_STROBE_N_O,
   output logic                     IO_WRITE_STROBE_N_O,
   output logic                     IO_READ_STROBE_N_O,
   input  wire logic                CYCLE_EXTEND_N_I,
   input  wire logic                IO_READ_ACK_N_I,
   input  wire logic                IRQ_OR_READY_N_I,
   input  wire logic                STATUS_CHANGE_N_I,
   input  wire logic                WIDE_IO_INDICATOR_N_I,
   input  wire logic [15:0]         HOST_DATA_BUS_I,
   output logic [15:0]              HOST_DATA_BUS_O,
   output logic                     HOST_DATA_BUS_OE_N_O
);
   // ----------------------------------------------------------------
   // Types and state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RESET, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD
   } state_t;

   state_t                     state_reg, state_next;
   logic [card_host_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [14:0]                rst_cnt_reg, rst_cnt_next;
   logic                       write_reg, write_next;
   logic [1:0]                 kind_reg, kind_next;
   logic [9:0]                 addr_reg, addr_next;
   logic [15:0]                wdata_reg, wdata_next;
   logic [15:0]                rdata_reg, rdata_next;
   logic                       rsp_reg, rsp_next;
   logic                       noack_reg, noack_next;
   logic                       ack_seen_reg, ack_seen_next;
   logic                       stat_fall;
   logic                       stat_low;
   logic                       wait_low;
   logic                       ready_low;

   localparam logic [card_host_pkg::CNT_W-1:0] SETUP_C =
      card_host_pkg::CNT_W'(card_host_pkg::SETUP_CYC);
   localparam logic [card_host_pkg::CNT_W-1:0] STROBE_C =
      card_host_pkg::CNT_W'(card_host_pkg::STROBE_CYC);
   localparam logic [card_host_pkg::CNT_W-1:0] HOLD_C =
      card_host_pkg::CNT_W'(card_host_pkg::HOLD_CYC);
   localparam logic [14:0] RESET_C = 15'(card_host_pkg::RESET_CYC);

   // Counter reload: first cycle of a phase counts as one
   function automatic logic [card_host_pkg::CNT_W-1:0] load
      (input logic [card_host_pkg::CNT_W-1:0] cyc);
      load = cyc - card_host_pkg::CNT_W'(1);
   endfunction

   // ----------------------------------------------------------------
   // Status change edge catcher
   // ----------------------------------------------------------------
   edge_catch u_stat
   (
      .clk_i     (CORE_CLK_I),
      .arst_n_i  (ARST_N_I),
      .level_n_i (STATUS_CHANGE_N_I),
      .level_o   (stat_low),
      .fall_o    (stat_fall)
   );

   assign STATUS_EVENT_O = stat_fall;
   assign wait_low       = ~CYCLE_EXTEND_N_I;
   assign ready_low      = ~IRQ_OR_READY_N_I;
   assign IRQ_O          = IO_MODE_I & ready_low;
   // Memory mode: low on the shared line means busy
   assign CARD_BUSY_O    = ~IO_MODE_I & ready_low;
   assign WIDE_IO_O      = ~WIDE_IO_INDICATOR_N_I;
   // Busy gates new accesses; reset also blocks them
   assign REQ_READY_O    = (state_reg == ST_IDLE) & ~CARD_BUSY_O;

   // ----------------------------------------------------------------
   // Access sequencer: next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      rst_cnt_next  = rst_cnt_reg;
      write_next    = write_reg;
      kind_next     = kind_reg;
      addr_next     = addr_reg;
      wdata_next    = wdata_reg;
      rdata_next    = rdata_reg;
      rsp_next      = 1'b0;
      noack_next    = noack_reg;
      ack_seen_next = ack_seen_reg;
      case (state_reg)
         ST_RESET:
         begin
            // Card reset held for the least pulse width
            if (rst_cnt_reg == 15'h0000)
               state_next = ST_IDLE;
            else
               rst_cnt_next = rst_cnt_reg - 15'h0001;
         end
         ST_IDLE:
         begin
            if (REQ_VALID_I && REQ_READY_O)
            begin
               write_next    = REQ_WRITE_I;
               kind_next     = REQ_KIND_I;
               addr_next     = REQ_ADDR_I;
               wdata_next    = REQ_WDATA_I;
               ack_seen_next = 1'b0;
               cnt_next      = load(SETUP_C);
               state_next    = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            if (cnt_reg == '0)
            begin
               cnt_next   = load(STROBE_C);
               state_next = ST_STROBE;
            end
            else
               cnt_next = cnt_reg - card_host_pkg::CNT_W'(1);
         end
         ST_STROBE:
         begin
            if (!IO_READ_ACK_N_I)
               ack_seen_next = 1'b1;
            if (cnt_reg != '0)
               cnt_next = cnt_reg - card_host_pkg::CNT_W'(1);
            // Strobe stays while the card extends the cycle
            else if (!wait_low)
            begin
               rdata_next = HOST_DATA_BUS_I;
               noack_next = ~write_reg &
                            (kind_reg == card_host_pkg::KIND_IO) &
                            ~(ack_seen_reg | ~IO_READ_ACK_N_I);
               cnt_next   = load(HOLD_C);
               state_next = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            if (cnt_reg == '0)
            begin
               rsp_next   = 1'b1;
               state_next = ST_IDLE;
            end
            else
               cnt_next = cnt_reg - card_host_pkg::CNT_W'(1);
         end
         default:
            state_next = ST_IDLE;
      endcase
      // User reset request overrides any access
      if (CARD_RESET_REQ_I)
      begin
         state_next   = ST_RESET;
         rst_cnt_next = RESET_C - 15'h0001;
      end
   end

   // Sequencer registers
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         state_reg    <= ST_RESET;
         cnt_reg      <= '0;
         rst_cnt_reg  <= RESET_C - 15'h0001;
         write_reg    <= 1'b0;
         kind_reg     <= 2'h0;
         addr_reg     <= 10'h000;
         wdata_reg    <= 16'h0000;
         rdata_reg    <= 16'h0000;
         rsp_reg      <= 1'b0;
         noack_reg    <= 1'b0;
         ack_seen_reg <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         rst_cnt_reg  <= rst_cnt_next;
         write_reg    <= write_next;
         kind_reg     <= kind_next;
         addr_reg     <= addr_next;
         wdata_reg    <= wdata_next;
         rdata_reg    <= rdata_next;
         rsp_reg      <= rsp_next;
         noack_reg    <= noack_next;
         ack_seen_reg <= ack_seen_next;
      end
   end

   // ----------------------------------------------------------------
   // Card pin drive
   // ----------------------------------------------------------------
   logic in_cycle;
   logic is_io;
   assign in_cycle = (state_reg == ST_SETUP) | (state_reg == ST_STROBE) |
                     (state_reg == ST_HOLD);
   assign is_io    = (kind_reg == card_host_pkg::KIND_IO);

   // Card reset is active high
   assign HOST_RESET_O         = (state_reg == ST_RESET);
   assign ADDR_O               = addr_reg;
   // Attribute space only for memory accesses
   assign ATTR_MEM_SELECT_N_O  = ~(in_cycle & (kind_reg ==
                                   card_host_pkg::KIND_ATTR));
   assign ODD_BYTE_ENABLE_N_O  = ~in_cycle;
   assign MEM_WRITE_STROBE_N_O = ~((state_reg == ST_STROBE) & write_reg &
                                   ~is_io);
   assign IO_WRITE_STROBE_N_O  = ~((state_reg == ST_STROBE) & write_reg &
                                   is_io);
   assign IO_READ_STROBE_N_O   = ~((state_reg == ST_STROBE) & ~write_reg &
                                   is_io);
   // Data driven through hold so the card latches stable data
   assign HOST_DATA_BUS_O      = wdata_reg;
   assign HOST_DATA_BUS_OE_N_O = ~(in_cycle & write_reg);
   assign RSP_VALID_O          = rsp_reg;
   assign RSP_RDATA_O          = rdata_reg;
   assign RSP_NO_ACK_O         = noack_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking assert_clk @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!ARST_N_I);
   a_strobe_waits: assert property (
      (state_reg == ST_STROBE) && wait_low && !CARD_RESET_REQ_I
      |=> (state_reg == ST_STROBE))
      else $error("strobe left while cycle extended");
   a_reset_pulse: assert property (
      $rose(HOST_RESET_O) |-> HOST_RESET_O[*8])
      else $error("card reset pulse too short");
   a_busy_blocks: assert property (CARD_BUSY_O |-> !REQ_READY_O)
      else $error("request accepted while card busy");
   a_bus_release: assert property (
      !IO_READ_STROBE_N_O |-> HOST_DATA_BUS_OE_N_O)
      else $error("host drives bus during read");
   a_one_strobe: assert property (
      $onehot0({~MEM_WRITE_STROBE_N_O, ~IO_WRITE_STROBE_N_O,
      ~IO_READ_STROBE_N_O})) else $error("two strobes active together");
   a_select_held: assert property (
      (state_reg == ST_STROBE) |-> !ODD_BYTE_ENABLE_N_O)
      else $error("select not asserted under strobe");
   a_attr_memonly: assert property (
      !ATTR_MEM_SELECT_N_O |-> IO_WRITE_STROBE_N_O && IO_READ_STROBE_N_O)
      else $error("attribute select on an I/O access");
   // A card reset may cut a write short, so it is excused here
   a_iowr_data: assert property (
      $rose(IO_WRITE_STROBE_N_O) && !HOST_RESET_O |-> !HOST_DATA_BUS_OE_N_O)
      else $error("write data dropped with strobe");
   a_irq_mode: assert property (!(IRQ_O && CARD_BUSY_O))
      else $error("interrupt and busy both shown");
   a_status_evt: assert property (STATUS_EVENT_O |-> stat_low)
      else $error("status event without low level");
   // Main scenarios: I/O read, memory write, extended cycle, status
   c_io_read: cover property ($fell(IO_READ_STROBE_N_O) ##[1:50] RSP_VALID_O);
   c_mem_write: cover property ($fell(MEM_WRITE_STROBE_N_O));
   c_extended: cover property ((state_reg == ST_STROBE) && wait_low
      && cnt_reg == '0);
   c_status: cover property (STATUS_EVENT_O);
endmodule

// ===== rtl/card_host_pkg.sv
// Purpose: Constants for the host-side card bus controller
// Assumes: 20 MHz core clock, active-low card strobes
// Notes:   Timing counts derive from times in nanoseconds
package card_host_pkg;
   // -----------------------------------------------------------------
   // Bus widths
   // -----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int ADDR_W = 10;
   localparam int CLK_PERIOD_NS = 50;
   // -----------------------------------------------------------------
   // Strobe timing
   // -----------------------------------------------------------------
   // Address setup before the strobe, least time
   localparam int SETUP_NS = 100;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Strobe width, least time
   localparam int STROBE_NS = 300;
   localparam int STROBE_CYC =
      (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Hold after strobe release, least time
   localparam int HOLD_NS = 50;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Card reset pulse width, least time
   localparam int RESET_NS = 10000;
   localparam int RESET_CYC = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // -----------------------------------------------------------------
   // Access kinds on the request port
   // -----------------------------------------------------------------
   localparam logic [1:0] KIND_COMMON = 2'h0;
   localparam logic [1:0] KIND_ATTR   = 2'h1;
   localparam logic [1:0] KIND_IO     = 2'h2;
endpackage

// ===== rtl/edge_catch.sv
// Purpose: Registered edge catcher for an active-low card level
// Assumes: Input is synchronous to the core clock
// Notes:   Reports a one-cycle pulse on a falling edge
`timescale 1ns/1ps
module edge_catch
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   // Level in
   input  wire logic level_n_i,
   // Level and edge out
   output logic      level_o,
   output logic      fall_o
);
   logic prev_reg;
   logic prev_next;
   logic fall_reg;
   logic fall_next;

   // Next values: active when low, pulse on high-to-low
   always_comb
   begin
      prev_next = level_n_i;
      fall_next = prev_reg & ~level_n_i;
   end

   // Registers; idle is high for active-low inputs
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         prev_reg <= 1'b1;
         fall_reg <= 1'b0;
      end
      else
      begin
         prev_reg <= prev_next;
         fall_reg <= fall_next;
      end
   end

   assign level_o = ~prev_reg;
   assign fall_o  = fall_reg;
endmodule

// ===== tb/card_model.sv
// Purpose: Behavioural card that answers the host port
// Assumes: Card outputs change on the core clock
// Notes:   Data lines have pull-downs; a released bus reads zero
`timescale 1ns/1ps
module card_model
(
   // Clock
   input  wire logic        clk_i,
   // Host pins
   input  wire logic [9:0]  addr_i,
   input  wire logic        attr_mem_select_n_i,
   input  wire logic        odd_byte_enable_n_i,
   input  wire logic        mem_write_strobe_n_i,
   input  wire logic        io_write_strobe_n_i,
   input  wire logic        io_read_strobe_n_i,
   input  wire logic [15:0] data_i,
   // Test controls
   input  wire logic [3:0]  wait_len_i,
   input  wire logic        no_ack_i,
   input  wire logic        irq_line_i,
   input  wire logic        bit_set_i,
   // Card pins
   output logic             cycle_extend_n_o,
   output logic             io_read_ack_n_o,
   output logic             irq_or_ready_n_o,
   output logic             status_change_n_o,
   output logic             wide_io_indicator_n_o,
   output logic [15:0]      data_o,
   output logic             data_en_o
);
   // -----------------------------------------------------------------
   // Storage and extend counter
   // -----------------------------------------------------------------
   logic [15:0] com_mem [1024];
   logic [15:0] att_mem [1024];
   logic [15:0] io_reg  [1024];
   logic [3:0]  wait_cnt = 4'h0;
   logic        strobe_d = 1'b0;
   logic        strobe;
   logic        sel;

   // Any strobe low marks a live cycle; sel is the odd select
   assign strobe = !(mem_write_strobe_n_i && io_write_strobe_n_i
                     && io_read_strobe_n_i);
   assign sel = !odd_byte_enable_n_i;

   // Writes land while strobed; extend counts from the strobe's fall
   always @(posedge clk_i)
   begin
      if (sel && !mem_write_strobe_n_i && !attr_mem_select_n_i)
         att_mem[addr_i] <= data_i;
      if (sel && !mem_write_strobe_n_i && attr_mem_select_n_i)
         com_mem[addr_i] <= data_i;
      if (sel && !io_write_strobe_n_i)
         io_reg[addr_i] <= data_i;
      strobe_d <= strobe;
      if (strobe && !strobe_d)
         wait_cnt <= wait_len_i;
      else if (wait_cnt != 4'h0)
         wait_cnt <= wait_cnt - 4'h1;
   end

   // Card answers; read data only while selected and not written
   assign cycle_extend_n_o = (wait_cnt == 4'h0);
   assign io_read_ack_n_o = !(sel && !io_read_strobe_n_i
                              && !no_ack_i);
   assign irq_or_ready_n_o = !irq_line_i;
   assign status_change_n_o = !bit_set_i;
   assign wide_io_indicator_n_o = 1'b0;
   assign data_en_o = sel && mem_write_strobe_n_i
                      && io_write_strobe_n_i;
   assign data_o = !io_read_strobe_n_i ? io_reg[addr_i] :
                   !attr_mem_select_n_i ? att_mem[addr_i] :
                   com_mem[addr_i];
endmodule

// ===== tb/test_card_bus_host_port.sv
// Purpose: Self-checking bench for the card bus host port
// Assumes: Card model answers synchronously to the core clock
// Notes:   Random traffic with fixed seed plus corner cases
`timescale 1ns/1ps
module test_card_bus_host_port;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic        clk, arst_n, req_valid, req_write, io_mode, crst_req;
   logic [1:0]  req_kind;
   logic [9:0]  req_addr, addr;
   logic [15:0] req_wdata, rsp_rdata, hd_o, hd, dev_d;
   logic        req_ready, rsp_valid, rsp_no_ack, irq, busy, st_event;
   logic        wide_io, host_reset, attr_n, odd_n, mwr_n, iowr_n, iord_n;
   logic        hd_oe_n, ext_n, ack_n, line_n, stchg_n, wide_n, dev_en;
   logic [3:0]  wait_len;
   logic        no_ack, irq_line, bit_set;
   int          miscompares, n_tests, bad_sel, bad_bus, seed;

   // Bus level: host first, then card, else pull-downs
   assign hd = !hd_oe_n ? hd_o : dev_en ? dev_d : 16'h0000;

   card_bus_host_port u_card_bus_host_port (.CORE_CLK_I(clk),
      .ARST_N_I(arst_n), .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready),
      .REQ_WRITE_I(req_write), .REQ_KIND_I(req_kind),
      .REQ_ADDR_I(req_addr), .REQ_WDATA_I(req_wdata), .IO_MODE_I(io_mode),
      .CARD_RESET_REQ_I(crst_req), .RSP_VALID_O(rsp_valid),
      .RSP_RDATA_O(rsp_rdata), .RSP_NO_ACK_O(rsp_no_ack), .IRQ_O(irq),
      .CARD_BUSY_O(busy), .STATUS_EVENT_O(st_event), .WIDE_IO_O(wide_io),
      .HOST_RESET_O(host_reset), .ADDR_O(addr),
      .ATTR_MEM_SELECT_N_O(attr_n), .ODD_BYTE_ENABLE_N_O(odd_n),
      .MEM_WRITE_STROBE_N_O(mwr_n), .IO_WRITE_STROBE_N_O(iowr_n),
      .IO_READ_STROBE_N_O(iord_n), .CYCLE_EXTEND_N_I(ext_n),
      .IO_READ_ACK_N_I(ack_n), .IRQ_OR_READY_N_I(line_n),
      .STATUS_CHANGE_N_I(stchg_n), .WIDE_IO_INDICATOR_N_I(wide_n),
      .HOST_DATA_BUS_I(hd), .HOST_DATA_BUS_O(hd_o),
      .HOST_DATA_BUS_OE_N_O(hd_oe_n));

   card_model u_card_model (.clk_i(clk), .addr_i(addr),
      .attr_mem_select_n_i(attr_n), .odd_byte_enable_n_i(odd_n),
      .mem_write_strobe_n_i(mwr_n), .io_write_strobe_n_i(iowr_n),
      .io_read_strobe_n_i(iord_n), .data_i(hd), .wait_len_i(wait_len),
      .no_ack_i(no_ack), .irq_line_i(irq_line), .bit_set_i(bit_set),
      .cycle_extend_n_o(ext_n), .io_read_ack_n_o(ack_n),
      .irq_or_ready_n_o(line_n), .status_change_n_o(stchg_n),
      .wide_io_indicator_n_o(wide_n), .data_o(dev_d), .data_en_o(dev_en));

   // -----------------------------------------------------------------
   // Clock, watchdog and bus monitor
   // -----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // About 1250 cycles are needed; sixteen times that is a hang
   initial
   begin
      #(20000 * 50);
      miscompares++;
      report_and_stop;
   end

   // Strobes need the odd select; reads need a released bus
   always @(negedge clk)
   begin
      if (!(mwr_n && iowr_n && iord_n) && odd_n !== 1'b0)
         bad_sel++;
      if (iord_n === 1'b0 && hd_oe_n !== 1'b1)
         bad_bus++;
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task report_and_stop;
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Entered just after a rising edge; returns the same way
   task automatic access(input logic w, input logic [1:0] k,
      input logic [9:0] a, input logic [15:0] d, output int lat);
      int n;
      n = 0;
      req_write = w;
      req_kind = k;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      #2 req_valid = 1'b0;
      lat = 0;
      while (rsp_valid !== 1'b1 && lat < 500)
      begin
         @(negedge clk);
         lat++;
      end
      // A limit that runs out is a failure of its own
      if (n >= 500 || lat >= 500)
         miscompares++;
      @(posedge clk);
      #2;
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      int n, lat;
      logic [1:0] k, o;
      logic [9:0] a;
      logic [15:0] d;
      seed = 32'h0328b0ef;
      {miscompares, n_tests, bad_sel, bad_bus} = '0;
      {arst_n, req_valid, req_write, crst_req, no_ack, bit_set} = '0;
      {io_mode, irq_line, wait_len} = 6'h20;
      {req_kind, req_addr, req_wdata} = '0;
      repeat (2) @(posedge clk);
      check("reset_pin", {15'h0, host_reset}, 16'h0001);
      #2 arst_n = 1'b1;
      n = 0;
      // Sampled mid-cycle; the first count falls before the first edge
      while (host_reset === 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      #2;
      check("reset_len", 16'(n), 16'(card_host_pkg::RESET_CYC + 1));
      check("wide_io", {15'h0, wide_io}, 16'h0001);
      // Write, write the other space, read back; ends are corners
      for (int i = 0; i < 24; i++)
      begin
         k = 2'($unsigned($random(seed)) % 3);
         a = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($random(seed));
         d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
         o = (k == card_host_pkg::KIND_COMMON) ? card_host_pkg::KIND_ATTR :
             card_host_pkg::KIND_COMMON;
         access(1'b1, k, a, d, lat);
         check("wr_lat", 16'(lat), 16'h000A);
         access(1'b1, o, a, ~d, lat);
         access(1'b0, k, a, 16'h0000, lat);
         check("rd_data", rsp_rdata, d);
         check("rd_ack", {15'h0, rsp_no_ack}, 16'h0000);
      end
      wait_len = 4'hC;
      access(1'b1, card_host_pkg::KIND_COMMON, 10'h005, 16'h1234, lat);
      check("ext_lat", 16'(lat > 10 && lat < 30), 16'h0001);
      wait_len = 4'h0;
      no_ack = 1'b1;
      access(1'b0, card_host_pkg::KIND_IO, 10'h005, 16'h0000, lat);
      check("no_ack", {15'h0, rsp_no_ack}, 16'h0001);
      no_ack = 1'b0;
      bit_set = 1'b1;
      n = 0;
      while (st_event !== 1'b1 && n < 5)
      begin
         @(negedge clk);
         n++;
      end
      check("st_event", {15'h0, st_event}, 16'h0001);
      @(posedge clk);
      #2 bit_set = 1'b0;
      irq_line = 1'b1;
      @(negedge clk);
      check("irq", {14'h0, irq, busy}, 16'h0002);
      @(posedge clk);
      #2 io_mode = 1'b0;
      @(negedge clk);
      check("busy", {13'h0, irq, busy, req_ready}, 16'h0002);
      @(posedge clk);
      #2 {io_mode, irq_line, crst_req} = 3'b101;
      @(posedge clk);
      #2 crst_req = 1'b0;
      repeat (3) @(negedge clk);
      check("card_rst", {15'h0, host_reset}, 16'h0001);
      n = 0;
      while (req_ready !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      check("rst_done", {14'h0, host_reset, req_ready}, 16'h0001);
      check("odd_sel", 16'(bad_sel), 16'h0000);
      check("bus_free", 16'(bad_bus), 16'h0000);
      report_and_stop;
   end
endmodule
